// file: common/irq_ctrl_regs.vh
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH
`define EXT_PRIO_ADDR 8'hF6
`define EXT_PRIO_RESET 8'h00
`define BASE_PRIO_RESET 8'h00
`define IRQ_SRC_COUNT 15
`define IRQ_SRC_LAST 14
`define SLOT_IDX_W 4
`define RESET_VECTOR 16'h0000
`define VECTOR_BASE 16'h0003
`define VECTOR_STEP_SHIFT 3
`define SLOT_EXT_A 4'h0
`define SLOT_TMR0 4'h1
`define SLOT_EXT_B 4'h2
`define SLOT_TMR1 4'h3
`define SLOT_RSVD 4'h8
`define SLOT_NONE 4'hF
`define DETECT_CYCLES 3'h1
`define CALL_CYCLES 3'h4
`define PRIO_TWOWIRE_BIT 0
`define PRIO_RSVD_BIT 1
`define PRIO_EXT_LOW 7
`define PRIO_EXT_HIGH 14
`define PIN_SEL_W 3
`define PIN_COUNT 8
`endif

// file: core/ext_irq_input.v
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module ext_irq_input (
  sys_clk,
  sys_rst,
  portPins,
  pinSelect,
  polarity,
  edgeSelect,
  vectorTaken,
  pending
);
  input wire sys_clk;
  input wire sys_rst;
  input wire [`PIN_COUNT-1:0] portPins;
  input wire [`PIN_SEL_W-1:0] pinSelect;
  input wire polarity;
  input wire edgeSelect;
  input wire vectorTaken;
  output wire pending;

  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg stable_reg;
  reg edgeFlag_reg;
  wire activeLevel;
  wire activeEdge;

  // pin tap only
  // Pin is only read here, so any peripheral driving it is undisturbed
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // Start at the inactive level, else a level input looks active out of reset
      sync1_reg <= ~polarity;
      sync2_reg <= ~polarity;
      sync3_reg <= ~polarity;
      stable_reg <= ~polarity;
    end else begin
      sync1_reg <= portPins[pinSelect];
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        stable_reg <= sync3_reg;
      end
    end
  end

  assign activeLevel = polarity ? stable_reg : ~stable_reg;
  assign activeEdge = (polarity ? sync3_reg : ~sync3_reg) & (sync2_reg == sync3_reg) &
    ~activeLevel;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      edgeFlag_reg <= 1'b0;
    end else if (!edgeSelect) begin
      edgeFlag_reg <= 1'b0;
    end else if (activeEdge) begin
      edgeFlag_reg <= 1'b1;
    end else if (vectorTaken) begin
      edgeFlag_reg <= 1'b0;
    end
  end

  assign pending = edgeSelect ? edgeFlag_reg : activeLevel;
endmodule // ext_irq_input

// file: core/two_level_irq_ctrl.v
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
// Overview of operation
// - Each external input has its own polarity and edge/level choice.
// - Edge select 1 means edge, polarity 1 means active high.
// - Each external input taps a chosen port pin without driving it.
// - Edge-mode pending flag clears when the core vectors to it.
// - Level-mode pending follows the input's active level directly.
// - Per-source two priority levels; high preempts low, never preempted.
// - Extended priority bits reset to low; slots 0-6 take their level from the basePriority input.
// - Higher level wins; equal levels decided by lowest slot number.
// - Sample and decode every cycle; fastest response five cycles.
// - After return from interrupt, one more instruction runs before call.
// - Worst case response eighteen cycles including return and divide.
// - Equal or higher running routine blocks until return plus one instruction.
// - Reset vector 0x0000, fifteen slots from 0x0003 eight bytes apart.
// - Extended priority register holds the high-priority bits of slots 7 and 9-14; bit 1 is reserved.
module two_level_irq_ctrl (
  sys_clk,
  sys_rst,
  portPins,
  extAPinSel,
  extBPinSel,
  extAPolarity,
  extBPolarity,
  extAEdgeSelect,
  extBEdgeSelect,
  basePriority,
  srcEnable,
  periphPending,
  regAddr,
  regWrite,
  regWdata,
  regRdata,
  instrBoundary,
  retiExec,
  irqRequest,
  irqVector,
  vectorAck,
  extAPending,
  extBPending,
  resetVector,
  activeHigh,
  activeLow
);
  input wire sys_clk;
  input wire sys_rst;
  input wire [`PIN_COUNT-1:0] portPins;
  input wire [`PIN_SEL_W-1:0] extAPinSel;
  input wire [`PIN_SEL_W-1:0] extBPinSel;
  input wire extAPolarity;
  input wire extBPolarity;
  input wire extAEdgeSelect;
  input wire extBEdgeSelect;
  input wire [`PRIO_EXT_LOW-1:0] basePriority;
  input wire [`IRQ_SRC_LAST:0] srcEnable;
  input wire [`IRQ_SRC_LAST:0] periphPending;
  input wire [7:0] regAddr;
  input wire regWrite;
  input wire [7:0] regWdata;
  output wire [7:0] regRdata;
  input wire instrBoundary;
  input wire retiExec;
  output reg irqRequest;
  output reg [15:0] irqVector;
  input wire vectorAck;
  output wire extAPending;
  output wire extBPending;
  output wire [15:0] resetVector;
  output wire activeHigh;
  output wire activeLow;

  localparam ST_IDLE = 3'b001;
  localparam ST_REQ = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg [7:0] extPrio_reg;
  reg actHigh_reg;
  reg actLow_reg;
  reg [3:0] slot_reg;
  reg slotHigh_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] readData_reg;
  reg extAAck;
  reg extBAck;
  wire [`IRQ_SRC_LAST:0] pendAll;
  wire [`IRQ_SRC_LAST:0] prioAll;
  wire [`IRQ_SRC_LAST:0] hiReq;
  wire [`IRQ_SRC_LAST:0] loReq;
  wire [3:0] hiSlot;
  wire [3:0] loSlot;
  wire hiAny;
  wire loAny;
  wire canHigh;
  wire canLow;
  wire callDone;

  // Lowest set slot number wins
  function [3:0] first_slot;
    input [`IRQ_SRC_LAST:0] req;
    integer i;
    begin
      first_slot = `SLOT_NONE;
      for (i = `IRQ_SRC_LAST; i >= 0; i = i - 1) begin
        if (req[i]) begin
          first_slot = i[3:0];
        end
      end
    end
  endfunction

  function [15:0] slot_vector;
    input [3:0] slot;
    begin
      slot_vector = `VECTOR_BASE + ({12'h000, slot} << `VECTOR_STEP_SHIFT);
    end
  endfunction

  function slot_acked;
    input [3:0] slot;
    input [3:0] want;
    input done;
    begin
      slot_acked = done && (slot == want);
    end
  endfunction

  ext_irq_input extA (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .portPins(portPins),
    .pinSelect(extAPinSel),
    .polarity(extAPolarity),
    .edgeSelect(extAEdgeSelect),
    .vectorTaken(extAAck),
    .pending(extAPending)
  );

  ext_irq_input extB (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .portPins(portPins),
    .pinSelect(extBPinSel),
    .polarity(extBPolarity),
    .edgeSelect(extBEdgeSelect),
    .vectorTaken(extBAck),
    .pending(extBPending)
  );

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      extPrio_reg <= `EXT_PRIO_RESET;
    end else if (regWrite && regAddr == `EXT_PRIO_ADDR) begin
      extPrio_reg <= regWdata;
      // Reserved position stays low
      extPrio_reg[`PRIO_RSVD_BIT] <= 1'b0;
    end
  end

  // Read data is registered, so a write shows one clock later
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      readData_reg <= `EXT_PRIO_RESET;
    end else if (regAddr == `EXT_PRIO_ADDR) begin
      readData_reg <= extPrio_reg;
    end else begin
      readData_reg <= 8'h00;
    end
  end

  assign regRdata = readData_reg;

  // Peripheral flags are owned and cleared by their peripherals
  assign pendAll = {periphPending[`IRQ_SRC_LAST:3], extBPending, periphPending[1],
    extAPending} & srcEnable & ~(15'h0001 << `SLOT_RSVD);
  assign prioAll = {extPrio_reg[7:2], 1'b0, extPrio_reg[`PRIO_TWOWIRE_BIT], basePriority};

  assign hiReq = pendAll & prioAll;
  assign loReq = pendAll & ~prioAll;
  assign hiSlot = first_slot(hiReq);
  assign loSlot = first_slot(loReq);
  assign hiAny = |hiReq;
  assign loAny = |loReq;

  assign canHigh = ~actHigh_reg;
  assign canLow = ~actHigh_reg & ~actLow_reg;
  assign callDone = (state_reg == ST_REQ) && vectorAck;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // detect at a boundary; a return is not one, so exactly
        // one further instruction runs before the call
        if (instrBoundary && !retiExec && ((hiAny && canHigh) || (loAny && canLow))) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (vectorAck) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      irqRequest <= 1'b0;
      irqVector <= `RESET_VECTOR;
      slot_reg <= `SLOT_NONE;
      slotHigh_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && state_next == ST_REQ) begin
        irqRequest <= 1'b1;
        if (hiAny && canHigh) begin
          slot_reg <= hiSlot;
          slotHigh_reg <= 1'b1;
          irqVector <= slot_vector(hiSlot);
        end else begin
          slot_reg <= loSlot;
          slotHigh_reg <= 1'b0;
          irqVector <= slot_vector(loSlot);
        end
      end else if (callDone) begin
        irqRequest <= 1'b0;
      end
    end
  end

  always @* begin
    extAAck = slot_acked(slot_reg, `SLOT_EXT_A, callDone);
    extBAck = slot_acked(slot_reg, `SLOT_EXT_B, callDone);
  end

  // in-service tracking, closed by the return itself
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      actHigh_reg <= 1'b0;
      actLow_reg <= 1'b0;
    end else begin
      // A return closes the highest routine still open
      if (retiExec) begin
        if (actHigh_reg) begin
          actHigh_reg <= 1'b0;
        end else begin
          actLow_reg <= 1'b0;
        end
      end
      // Last, so a call in the cycle of a return still opens its level
      if (callDone) begin
        if (slotHigh_reg) begin
          actHigh_reg <= 1'b1;
        end else begin
          actLow_reg <= 1'b1;
        end
      end
    end
  end

  assign resetVector = `RESET_VECTOR;
  assign activeHigh = actHigh_reg;
  assign activeLow = actLow_reg;
endmodule // two_level_irq_ctrl

// file: verification/two_level_irq_ctrl_checker.sv
`timescale 1ns/1ps
module two_level_irq_ctrl_checker (
  input logic sys_clk,
  input logic sys_rst,
  input logic instrBoundary,
  input logic retiExec,
  input logic irqRequest,
  input logic [15:0] irqVector,
  input logic vectorAck,
  input logic extAEdgeSelect,
  input logic extAPending,
  input logic [15:0] resetVector,
  input logic activeHigh,
  input logic activeLow,
  input logic [14:0] periphPending,
  input logic [14:0] srcEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_stand; irqRequest && !vectorAck |=> irqRequest && $stable(irqVector); endproperty
  a_stand: assert property (p_stand) else $error("request dropped");
  property p_rise; $rose(irqRequest) |-> $past(instrBoundary); endproperty
  a_rise: assert property (p_rise) else $error("request off boundary");
  property p_ack; vectorAck && !instrBoundary |=> !irqRequest; endproperty
  a_ack: assert property (p_ack) else $error("request after call");
  property p_vec;
    irqRequest |-> irqVector[2:0] == 3'h3 && irqVector <= 16'h0073 && irqVector != 16'h0043;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_rvec; resetVector == 16'h0000; endproperty
  a_rvec: assert property (p_rvec) else $error("bad reset vector");
  property p_irq_return_instr; retiExec && !instrBoundary |=> !$rose(irqRequest); endproperty
  a_irq_return_instr: assert property (p_irq_return_instr) else $error("call right after return");
  property p_eclr;
    extAEdgeSelect && vectorAck && irqVector == 16'h0003 |=> !extAPending;
  endproperty
  a_eclr: assert property (p_eclr) else $error("edge flag kept");
  property p_hi; activeHigh && $past(activeHigh) |-> !$rose(irqRequest); endproperty
  a_hi: assert property (p_hi) else $error("high routine preempted");
  property p_one;
    retiExec ##1 !instrBoundary ##1 (instrBoundary && !activeHigh && !activeLow &&
      |(periphPending & srcEnable & 15'h7EFA)) |=> $rose(irqRequest);
  endproperty
  a_one: assert property (p_one) else $error("call not after one instruction");
  c_req: cover property ($rose(irqRequest));
  c_irq_return_instr: cover property (retiExec ##[1:20] $rose(irqRequest));
  c_hi: cover property (activeHigh && vectorAck);
endmodule // two_level_irq_ctrl_checker
bind two_level_irq_ctrl two_level_irq_ctrl_checker two_level_irq_ctrl_checker_i (.sys_clk,
  .sys_rst, .instrBoundary, .retiExec, .irqRequest, .irqVector, .vectorAck, .extAEdgeSelect,
  .extAPending, .resetVector, .activeHigh, .activeLow, .periphPending, .srcEnable);

// file: verification/core_model.sv
`timescale 1ns/1ps
module core_model (
  input logic sys_clk,
  input logic sys_rst,
  input logic irqRequest,
  output logic instrBoundary = 1'b0,
  output logic retiExec = 1'b0,
  output logic vectorAck = 1'b0
);
  int cyc = 0;
  int depth[$];
  always @(negedge sys_clk) begin
    instrBoundary <= 1'b0;
    retiExec <= 1'b0;
    vectorAck <= 1'b0;
    cyc++;
    if (sys_rst) begin
      cyc = 0;
      depth.delete();
    end else if (irqRequest) begin
      if (cyc == 4) begin
        vectorAck <= 1'b1;
        depth.push_back(6);
        cyc = 0;
      end
    end else if (cyc == 2) begin
      cyc = 0;
      // each routine ends in a return
      if (depth.size() && depth[$] == 1) begin
        retiExec <= 1'b1;
        void'(depth.pop_back());
      end else begin
        instrBoundary <= 1'b1;
        if (depth.size()) depth[$] = depth[$] - 1;
      end
    end
  end
endmodule // core_model

// file: verification/two_level_irq_ctrl_test.sv
`timescale 1ns/1ps
module two_level_irq_ctrl_test;
  logic sys_clk = 0, sys_rst = 1, extAPolarity, extBPolarity, extAEdgeSelect = 1, inj = 0;
  logic extBEdgeSelect = 0, regWrite = 0, instrBoundary, retiExec, irqRequest, vectorAck;
  logic extAPending, extBPending, activeHigh, activeLow, drop = 0;
  logic [7:0] portPins, regAddr = 8'hF6, regWdata = 8'h00, regRdata, prio = 8'h00;
  logic [2:0] extAPinSel, extBPinSel;
  logic [6:0] basePriority;
  logic [14:0] srcEnable, periphPending = 15'h0100, pend = 15'h0000;
  logic [15:0] irqVector, resetVector, lfsr = 16'hDDA5;
  int n_errors = 0, compares = 0, acks = 0, best, s, stk[$];
  two_level_irq_ctrl two_level_irq_ctrl_i (.*);
  core_model core_model_i (.*);
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic int lvl(int k);
    return k < 7 ? basePriority[k] : prio[k - 7];
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_acks(int n);
    int t;
    t = acks + n;
    for (int i = 0; i < 400 * n && acks < t; i++) @(negedge sys_clk);
    if (acks < t) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // reference arbiter, slot 8 always raised but never due
  always @(posedge sys_clk) begin
    if (retiExec) void'(stk.pop_back());
    if (vectorAck) begin
      best = -1;
      for (int k = 0; k < 15; k++)
        if (pend[k] && srcEnable[k] && lvl(k) > (stk.size() ? stk[$] : -1)
            && (best < 0 || lvl(k) > lvl(best))) best = k;
      check(irqVector, 16'h0003 + 16'(best) * 16'h0008);
      stk.push_back(lvl(best));
      pend[best] = 1'b0;
      if (best == 2) drop = 1;
      if (inj) begin
        s = rnd() % 10 + 4;
        pend[s + (s > 7)] = 1'b1;
        // Keep one enabled source due so the run cannot stall
        if ((pend & srcEnable & 15'h7EF0) == 0) pend[4] = 1'b1;
      end
      acks++;
    end
  end
  always @(negedge sys_clk) begin
    periphPending <= pend | 15'h0100;
    if (drop) portPins[extBPinSel] <= ~extBPolarity;
    drop = 0;
  end
  initial begin
    void'(rnd());
    extAPinSel = {1'b0, lfsr[1:0]};
    extBPinSel = {1'b1, lfsr[3:2]};
    {extBPolarity, extAPolarity} = lfsr[5:4];
    basePriority = lfsr[12:6];
    void'(rnd());
    srcEnable = lfsr[14:0] | 15'h0015;
    portPins = lfsr[15:8];
    portPins[extAPinSel] = ~extAPolarity;
    portPins[extBPinSel] = ~extBPolarity;
    repeat (5) @(negedge sys_clk);
    sys_rst = 0;
    #1 check(regRdata, 8'h00);
    regWdata = rnd();
    regWrite = 1;
    @(negedge sys_clk);
    regWrite = 0;
    prio = regWdata & 8'hFD;
    @(negedge sys_clk);
    check(regRdata, prio);
    portPins[extAPinSel] = extAPolarity;
    pend[0] = 1;
    wait_acks(1);
    repeat (2) @(negedge sys_clk);
    check(extAPending, 0);
    portPins[extBPinSel] = extBPolarity;
    pend[2] = 1;
    repeat (4) @(negedge sys_clk);
    check(extBPending, 1);
    wait_acks(1);
    repeat (5) @(negedge sys_clk);
    check(extBPending, 0);
    inj = 1;
    pend = (lfsr[14:0] & 15'h7EF0) | 15'h0010;
    wait_acks(40);
    end_of_test();
  end
endmodule // two_level_irq_ctrl_test
